/* File: logic/cfpc_bank.sv */
// Purpose: one output bank: post-loop divider, synchronous gate, enable
// Assumes: src_tick is a one-cycle enable from the vco or prescaler
// Notes: gate decisions are made on mclk, while the bank's own divided clock sits at idle
module cfpc_bank (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic src_tick,
	input wire cfpc_pkg::cfpc_bank_cfg_s cfg,
	input wire logic gate,
	input wire logic oe_first,
	input wire logic oe_second,
	input wire logic global_dis,
	output logic out_r,
	output logic oe_n_r
);
	logic [3:0] cnt_r;
	logic clk_r;
	logic gate_act_r;
	logic wrap;
	logic en;

	assign wrap = src_tick && (cnt_r == cfg.div);

	// divider: half period is div+1 source ticks
	always_ff @(posedge mclk) begin
		if (!rst_n || clr) begin
			cnt_r <= 4'h0;
			clk_r <= 1'b0;
		end else if (wrap) begin
			cnt_r <= 4'h0;
			clk_r <= !clk_r;
		end else if (src_tick) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// gate only moves while the bank sits at idle and will stay there;
	// a loop clear may force the clock off idle, so the gate waits it out
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gate_act_r <= 1'b1;
		end else if (!cfg.gate_en) begin
			gate_act_r <= 1'b1;
		end else if (!clr && clk_r == cfg.idle_lvl && !wrap) begin
			gate_act_r <= gate;
		end
	end

	// output level: clock or constant idle level
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			out_r <= 1'b0;
		end else begin
			out_r <= gate_act_r ? clk_r : cfg.idle_lvl;
		end
	end

	// enable source, global disable overrides all
	always_comb begin
		case (cfg.oe_src)
			cfpc_pkg::OE_ALWAYS_ON: en = 1'b1;
			cfpc_pkg::OE_ALWAYS_OFF: en = 1'b0;
			cfpc_pkg::OE_FIRST_PIN: en = oe_first;
			default: en = oe_second;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= global_dis || !en;
		end
	end

	a_gate_hold_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg.gate_en && !gate_act_r |=> out_r == $past(cfg.idle_lvl))
		else $error("gated bank not at idle level");
	a_gate_no_runt: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(gate_act_r) && cfg.gate_en |-> clk_r == cfg.idle_lvl)
		else $error("gate moved away from idle level");
	a_global_off: assert property (@(posedge mclk) disable iff (!rst_n)
		global_dis |=> oe_n_r)
		else $error("output driven under global disable");
	a_oe_first_pin: assert property (@(posedge mclk) disable iff (!rst_n)
		!global_dis && cfg.oe_src == cfpc_pkg::OE_FIRST_PIN |=> oe_n_r == !$past(oe_first))
		else $error("enable does not follow first pin");
	a_oe_off: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg.oe_src == cfpc_pkg::OE_ALWAYS_OFF |=> oe_n_r)
		else $error("always-off output driven");
endmodule : cfpc_bank

/* File: logic/cfpc_consts.svh */
// Purpose: offsets, field positions, reset values and counts of the pin control block
// Assumes: byte addresses on the register bus, one aligned 32-bit word per register
// Notes: types live in cfpc_pkg
`ifndef CFPC_CONSTS_SVH
`define CFPC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CFPC_ADDR_W 6
`define CFPC_OFS_PIN_STATUS 6'h00
`define CFPC_OFS_IRQ_STATUS 6'h04
`define CFPC_OFS_IRQ_MASK 6'h08
`define CFPC_OFS_PRE_DIV 6'h0C
`define CFPC_OFS_VCO_DIV 6'h10
`define CFPC_OFS_LOCK_THR 6'h14
`define CFPC_OFS_PROFILE0 6'h20
`define CFPC_OFS_PROFILE1 6'h24
`define CFPC_OFS_PROFILE2 6'h28
`define CFPC_OFS_PROFILE3 6'h2C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CFPC_IRQ_W 3
`define CFPC_IRQ_LOCK_GAIN 0
`define CFPC_IRQ_LOCK_LOSS 1
`define CFPC_IRQ_PROFILE 2
`define CFPC_DIV_W 5
`define CFPC_THR_W 8
`define CFPC_PRE_DIV_RST 5'h00
`define CFPC_VCO_DIV_RST 5'h01
`define CFPC_LOCK_THR_RST 8'h08
`define CFPC_PROFILE_RST 32'h00000000
`define CFPC_NPROFILE 4
`define CFPC_NBANK 4

`endif

/* File: logic/cfpc_pin_control.sv */
// Purpose: pin control of a zero-delay clock fan-out buffer
// Assumes: every board pin, clock pins too, is sampled by mclk at 40 MHz
// Notes: loop and vco are modelled by tick enables; Avalon-MM slave for control
`include "cfpc_consts.svh"
module cfpc_pin_control #(
	parameter int NBANK = `CFPC_NBANK
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire cfpc_pkg::cfpc_pins_s pins,
	input wire logic [`CFPC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic lock_n,
	output logic [NBANK-1:0] bank_out,
	output logic [NBANK-1:0] bank_oe_n
);
	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	cfpc_pkg::cfpc_pins_s pin_s;
	logic [$bits(cfpc_pkg::cfpc_pins_s)-1:0] pin_q;

	cfpc_sync2 #(
		.W($bits(cfpc_pkg::cfpc_pins_s))
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(pins),
		.q(pin_q)
	);
	assign pin_s = cfpc_pkg::cfpc_pins_s'(pin_q);

	// ----------------------------------------
	// registers and control state
	// ----------------------------------------
	logic [`CFPC_DIV_W-1:0] pre_div_r;
	logic [`CFPC_DIV_W-1:0] vco_div_r;
	logic [`CFPC_THR_W-1:0] lock_thr_r;
	logic [31:0] prof_mem_r [`CFPC_NPROFILE];
	logic [`CFPC_IRQ_W-1:0] irq_sts_r;
	logic [`CFPC_IRQ_W-1:0] irq_mask_r;
	logic [`CFPC_IRQ_W-1:0] irq_evt;
	logic ack_r;
	logic req;
	logic wr_go;
	logic rd_go;

	logic ref_sel;
	logic fb_sel;
	logic ref_d_r;
	logic fb_d_r;
	logic ref_rise;
	logic fb_rise;
	logic fb_buf_en;
	logic fb_seen_r;
	logic loop_clr;

	logic [`CFPC_DIV_W-1:0] pre_cnt_r;
	logic [`CFPC_DIV_W-1:0] vco_cnt_r;
	logic pre_tick;
	logic vco_tick;
	logic src_tick;

	cfpc_pkg::cfpc_lock_st_e lock_st_r;
	cfpc_pkg::cfpc_lock_st_e lock_st_nxt;
	logic [`CFPC_THR_W-1:0] lock_cnt_r;
	logic [`CFPC_THR_W-1:0] lock_cnt_nxt;
	logic lock_n_r;

	logic [1:0] prof_idx_r;
	logic [1:0] prof_pin;
	logic [31:0] prof_word;

	// ----------------------------------------
	// input pair selection
	// ----------------------------------------
	// reference and feedback muxes after synchronisation
	assign ref_sel = pin_s.reference_pair_select ? pin_s.ref_b : pin_s.ref_a;
	assign fb_sel = pin_s.feedback_pair_select ?
		pin_s.feedback_input_b : pin_s.feedback_input_a;
	// global disable also switches off the feedback buffer
	assign fb_buf_en = !pin_s.global_output_disable;
	assign loop_clr = pin_s.loop_reset;

	// edge detectors read only the settled second stage
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ref_d_r <= 1'b0;
			fb_d_r <= 1'b0;
		end else begin
			ref_d_r <= ref_sel;
			fb_d_r <= fb_sel && fb_buf_en;
		end
	end
	assign ref_rise = ref_sel && !ref_d_r;
	assign fb_rise = fb_sel && fb_buf_en && !fb_d_r;

	// ----------------------------------------
	// prescaler and vco ticks
	// ----------------------------------------
	// input prescaler divides reference edges by pre_div+1
	always_ff @(posedge mclk) begin
		if (!rst_n || loop_clr) begin
			pre_cnt_r <= '0;
		end else if (ref_rise) begin
			pre_cnt_r <= (pre_cnt_r == pre_div_r) ? '0 : pre_cnt_r + 5'h01;
		end
	end
	assign pre_tick = ref_rise && (pre_cnt_r == pre_div_r);

	// vco stand-in: free divider of mclk, not phase-steered
	always_ff @(posedge mclk) begin
		if (!rst_n || loop_clr) begin
			vco_cnt_r <= '0;
		end else begin
			vco_cnt_r <= (vco_cnt_r == vco_div_r) ? '0 : vco_cnt_r + 5'h01;
		end
	end
	assign vco_tick = vco_cnt_r == vco_div_r;

	// bypass routes the prescaler straight to the post-loop dividers
	assign src_tick = pin_s.loop_bypass ? pre_tick : vco_tick;

	// ----------------------------------------
	// lock detection
	// ----------------------------------------
	// remembers a feedback edge within the current prescaler period
	always_ff @(posedge mclk) begin
		if (!rst_n || loop_clr || !fb_buf_en) begin
			fb_seen_r <= 1'b0;
		end else if (pre_tick) begin
			fb_seen_r <= fb_rise;
		end else if (fb_rise) begin
			fb_seen_r <= 1'b1;
		end
	end

	// lock needs lock_thr consecutive periods with feedback
	always_comb begin
		lock_st_nxt = lock_st_r;
		lock_cnt_nxt = lock_cnt_r;
		case (lock_st_r)
			cfpc_pkg::LK_UNLOCKED: begin
				if (pre_tick && fb_seen_r) begin
					lock_st_nxt = cfpc_pkg::LK_ACQUIRE;
					lock_cnt_nxt = 8'h01;
				end
			end
			cfpc_pkg::LK_ACQUIRE: begin
				if (pre_tick && !fb_seen_r) begin
					lock_st_nxt = cfpc_pkg::LK_UNLOCKED;
					lock_cnt_nxt = 8'h00;
				end else if (pre_tick) begin
					lock_cnt_nxt = lock_cnt_r + 8'h01;
					if (lock_cnt_nxt >= lock_thr_r) begin
						lock_st_nxt = cfpc_pkg::LK_LOCKED;
					end
				end
			end
			cfpc_pkg::LK_LOCKED: begin
				if (pre_tick && !fb_seen_r) begin
					lock_st_nxt = cfpc_pkg::LK_UNLOCKED;
					lock_cnt_nxt = 8'h00;
				end
			end
			default: begin
				lock_st_nxt = cfpc_pkg::LK_UNLOCKED;
				lock_cnt_nxt = 8'h00;
			end
		endcase
		// losing feedback or a loop reset drops lock at once
		if (loop_clr || !fb_buf_en) begin
			lock_st_nxt = cfpc_pkg::LK_UNLOCKED;
			lock_cnt_nxt = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lock_st_r <= cfpc_pkg::LK_UNLOCKED;
			lock_cnt_r <= 8'h00;
			lock_n_r <= 1'b1;
		end else begin
			lock_st_r <= lock_st_nxt;
			lock_cnt_r <= lock_cnt_nxt;
			lock_n_r <= lock_st_nxt != cfpc_pkg::LK_LOCKED;
		end
	end
	assign lock_n = lock_n_r;

	// ----------------------------------------
	// profile selection
	// ----------------------------------------
	assign prof_pin = {pin_s.profile_select_bit1, pin_s.profile_select_bit0};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prof_idx_r <= 2'h0;
		end else begin
			prof_idx_r <= prof_pin;
		end
	end
	assign prof_word = prof_mem_r[prof_idx_r];

	// ----------------------------------------
	// output banks
	// ----------------------------------------
	generate
		for (genvar b = 0; b < NBANK; b++) begin : g_bank
			cfpc_bank u_bank (
				.mclk(mclk),
				.rst_n(rst_n),
				.clr(loop_clr),
				.src_tick(src_tick),
				.cfg(cfpc_pkg::cfpc_bank_cfg_s'(prof_word[8*b +: 8])),
				.gate(pin_s.sync_output_gate),
				.oe_first(pin_s.output_enable_first),
				.oe_second(pin_s.output_enable_second),
				.global_dis(pin_s.global_output_disable),
				.out_r(bank_out[b]),
				.oe_n_r(bank_oe_n[b])
			);
		end
	endgenerate

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// one wait cycle per access: waitrequest drops the cycle after request
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !ack_r;
	assign wr_go = avs_write && ack_r;
	assign rd_go = avs_read && !ack_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end

	// configuration writes take effect at the accepting edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pre_div_r <= `CFPC_PRE_DIV_RST;
			vco_div_r <= `CFPC_VCO_DIV_RST;
			lock_thr_r <= `CFPC_LOCK_THR_RST;
			irq_mask_r <= '0;
		end else if (wr_go) begin
			if (avs_address == `CFPC_OFS_PRE_DIV) begin
				pre_div_r <= avs_writedata[`CFPC_DIV_W-1:0];
			end else if (avs_address == `CFPC_OFS_VCO_DIV) begin
				vco_div_r <= avs_writedata[`CFPC_DIV_W-1:0];
			end else if (avs_address == `CFPC_OFS_LOCK_THR) begin
				lock_thr_r <= avs_writedata[`CFPC_THR_W-1:0];
			end else if (avs_address == `CFPC_OFS_IRQ_MASK) begin
				irq_mask_r <= avs_writedata[`CFPC_IRQ_W-1:0];
			end
		end
	end

	// stored profiles, selected by the profile pins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int p = 0; p < `CFPC_NPROFILE; p++) begin
				prof_mem_r[p] <= `CFPC_PROFILE_RST;
			end
		end else if (wr_go && avs_address[5:4] == 2'h2 && avs_address[1:0] == 2'h0) begin
			prof_mem_r[avs_address[3:2]] <= avs_writedata;
		end
	end

	// read data registered one edge before the accepting edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (rd_go) begin
			if (avs_address == `CFPC_OFS_PIN_STATUS) begin
				avs_readdata <= {25'h0000000, pin_s.sync_output_gate, pin_s.loop_reset,
					pin_s.global_output_disable, pin_s.loop_bypass, prof_idx_r,
					!lock_n_r};
			end else if (avs_address == `CFPC_OFS_IRQ_STATUS) begin
				avs_readdata <= {29'h00000000, irq_sts_r};
			end else if (avs_address == `CFPC_OFS_IRQ_MASK) begin
				avs_readdata <= {29'h00000000, irq_mask_r};
			end else if (avs_address == `CFPC_OFS_PRE_DIV) begin
				avs_readdata <= {27'h0000000, pre_div_r};
			end else if (avs_address == `CFPC_OFS_VCO_DIV) begin
				avs_readdata <= {27'h0000000, vco_div_r};
			end else if (avs_address == `CFPC_OFS_LOCK_THR) begin
				avs_readdata <= {24'h000000, lock_thr_r};
			end else if (avs_address[5:4] == 2'h2 && avs_address[1:0] == 2'h0) begin
				avs_readdata <= prof_mem_r[avs_address[3:2]];
			end else begin
				avs_readdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// events: lock gained, lock lost, profile switched
	always_comb begin
		irq_evt = '0;
		irq_evt[`CFPC_IRQ_LOCK_GAIN] = lock_n_r && lock_st_nxt == cfpc_pkg::LK_LOCKED;
		irq_evt[`CFPC_IRQ_LOCK_LOSS] = !lock_n_r && lock_st_nxt != cfpc_pkg::LK_LOCKED;
		irq_evt[`CFPC_IRQ_PROFILE] = prof_pin != prof_idx_r;
	end

	// write-one-to-clear, a new event in the same cycle wins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_sts_r <= '0;
		end else if (wr_go && avs_address == `CFPC_OFS_IRQ_STATUS) begin
			irq_sts_r <= (irq_sts_r & ~avs_writedata[`CFPC_IRQ_W-1:0]) | irq_evt;
		end else begin
			irq_sts_r <= irq_sts_r | irq_evt;
		end
	end
	assign irq = |(irq_sts_r & irq_mask_r);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_fb_pair_b: assert property (@(posedge mclk) disable iff (!rst_n)
		pin_s.feedback_pair_select && !pin_s.feedback_input_b |-> !fb_rise)
		else $error("feedback taken from pair A while B selected");
	a_ref_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!pin_s.reference_pair_select && !pin_s.ref_a |-> !ref_rise)
		else $error("reference taken from pair B while A selected");
	a_lock_pin_low: assert property (@(posedge mclk) disable iff (!rst_n)
		lock_st_r == cfpc_pkg::LK_LOCKED |-> !lock_n_r)
		else $error("lock pin high while locked");
	a_godis_unlock: assert property (@(posedge mclk) disable iff (!rst_n)
		pin_s.global_output_disable |=> lock_n_r && !fb_seen_r)
		else $error("lock held with feedback buffer off");
	a_reset_clears: assert property (@(posedge mclk) disable iff (!rst_n)
		pin_s.loop_reset |=> lock_n_r && pre_cnt_r == 5'h00 && vco_cnt_r == 5'h00)
		else $error("loop reset did not clear");
	a_bypass_src: assert property (@(posedge mclk) disable iff (!rst_n)
		pin_s.loop_bypass && !pre_tick |-> !src_tick)
		else $error("vco reached dividers in bypass");
	a_vco_src: assert property (@(posedge mclk) disable iff (!rst_n)
		!pin_s.loop_bypass |-> src_tick == (vco_cnt_r == vco_div_r))
		else $error("dividers not on vco");
	a_profile_idx: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(prof_pin) |=> prof_idx_r == $past(prof_pin))
		else $error("profile index not following pins");
	a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
		req && !ack_r |=> !avs_waitrequest || !req)
		else $error("bus answer late");
endmodule : cfpc_pin_control

/* File: logic/cfpc_pkg.sv */
// Purpose: shared types of the clock fan-out pin control block
// Assumes: nothing
// Notes: field layouts of a bank configuration byte are set by the struct
package cfpc_pkg;
	// output enable source of one bank
	typedef enum logic [1:0] {
		OE_ALWAYS_ON = 2'h0,
		OE_ALWAYS_OFF = 2'h1,
		OE_FIRST_PIN = 2'h2,
		OE_SECOND_PIN = 2'h3
	} cfpc_oe_src_e;

	// loop lock tracker, gray along unlock-acquire-locked
	typedef enum logic [1:0] {
		LK_UNLOCKED = 2'h0,
		LK_ACQUIRE = 2'h1,
		LK_LOCKED = 2'h3
	} cfpc_lock_st_e;

	// one byte of a profile word per bank
	typedef struct packed {
		logic idle_lvl;
		logic gate_en;
		cfpc_oe_src_e oe_src;
		logic [3:0] div;
	} cfpc_bank_cfg_s;

	// all pins that arrive from the board
	typedef struct packed {
		logic ref_a;
		logic ref_b;
		logic feedback_input_a;
		logic feedback_input_b;
		logic reference_pair_select;
		logic feedback_pair_select;
		logic sync_output_gate;
		logic output_enable_first;
		logic output_enable_second;
		logic global_output_disable;
		logic profile_select_bit1;
		logic profile_select_bit0;
		logic loop_bypass;
		logic loop_reset;
	} cfpc_pins_s;
endpackage : cfpc_pkg

/* File: logic/cfpc_sync2.sv */
// Purpose: two-flop synchroniser for board pins
// Assumes: inputs asynchronous to mclk
// Notes: first stage is read by the second stage only
module cfpc_sync2 #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// two stages, both cleared by reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : cfpc_sync2

/* File: verification/cfpc_board.sv */
// Purpose: board model: reference clock sources and feedback lines from the loads
// Assumes: one mclk domain; the references are derived from mclk, well below 20 MHz
// Notes: a released output line has no pull, so it shows the inverse of its last level
module cfpc_board (
	input wire logic mclk,
	input wire logic [3:0] bank_out,
	input wire logic [3:0] bank_oe_n,
	output logic ref_a,
	output logic ref_b,
	output logic fb_a,
	output logic fb_b
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_r = 4'h0;
	logic [1:0] last_r = 2'h0;
	// ----------------------------------------
	// reference sources: pair a 16 mclk, pair b 8 mclk
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		cnt_r <= cnt_r + 4'h1;
	end
	assign ref_a = cnt_r[3];
	assign ref_b = cnt_r[2];
	// ----------------------------------------
	// feedback lines: load of bank 0 on pair a, bank 1 on pair b
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!bank_oe_n[0]) last_r[0] <= bank_out[0];
		if (!bank_oe_n[1]) last_r[1] <= bank_out[1];
	end
	// floating line must not look like a clean copy of the old level
	assign fb_a = bank_oe_n[0] ? ~last_r[0] : bank_out[0];
	assign fb_b = bank_oe_n[1] ? ~last_r[1] : bank_out[1];
endmodule : cfpc_board

/* File: verification/cfpc_pin_control_test.sv */
// Purpose: self-checking bench of the clock fan-out pin control block
// Assumes: registers reached over Avalon-MM, one wait cycle per request
// Notes: profile 0 = bank0 on, bank1 off, bank2 first pin, bank3 second pin gated
`include "cfpc_consts.svh"
module cfpc_pin_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF3 = 2 * (`CFPC_VCO_DIV_RST + 1);
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	cfpc_pkg::cfpc_pins_s drv = '0;
	cfpc_pkg::cfpc_pins_s pins;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, irq, lock_n, ref_a, ref_b, fb_a, fb_b;
	logic [3:0] bank_out, bank_oe_n;
	int err_count = 0;
	int num_checks = 0;
	int p, tg;
	// board clocks and feedback join the bench-driven pins
	always_comb begin
		pins = drv;
		pins.ref_a = ref_a;
		pins.ref_b = ref_b;
		pins.feedback_input_a = fb_a;
		pins.feedback_input_b = fb_b;
	end
	cfpc_pin_control #(.NBANK(4)) dut (.mclk(mclk), .rst_n(rst_n), .pins(pins),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .lock_n(lock_n),
		.bank_out(bank_out), .bank_oe_n(bank_oe_n));
	cfpc_board board (.mclk(mclk), .bank_out(bank_out), .bank_oe_n(bank_oe_n),
		.ref_a(ref_a), .ref_b(ref_b), .fb_a(fb_a), .fb_b(fb_b));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	task chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk
	task ticks(input int n);
		repeat (n) @(posedge mclk);
	endtask : ticks
	// waitrequest taken at each rising edge; the request holds until it is seen low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			chk(1'b0, "bus timeout");
			results();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : bus
	task wait_lock(input logic v, input int lim);
		int n;
		n = 0;
		while (lock_n !== v && n < lim) begin
			@(posedge mclk);
			n++;
		end
		chk(lock_n === v, "lock pin level");
		if (lock_n !== v) results();
	endtask : wait_lock
	// counts toggles of bank 3; a completed run shorter than a half period is a cut pulse
	task runs(input int n, output int t);
		int len;
		logic prev;
		len = 0;
		t = 0;
		prev = bank_out[3];
		repeat (n) begin
			@(posedge mclk);
			len++;
			if (bank_out[3] !== prev) begin
				if (t > 0) chk(len >= HALF3, "short pulse on gated bank");
				t++;
				len = 0;
			end
			prev = bank_out[3];
		end
	endtask : runs
	task lvl(input logic v, inout int n);
		while (bank_out[0] !== v && n < 400) begin
			@(posedge mclk);
			n++;
		end
	endtask : lvl
	// period of bank 0, rising edge to rising edge
	task period(output int q);
		int n;
		ticks(80);
		n = 0;
		lvl(1'b0, n);
		lvl(1'b1, n);
		n = 0;
		lvl(1'b0, n);
		lvl(1'b1, n);
		q = n;
		chk(n < 400, "bank 0 not toggling");
	endtask : period
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		chk(lock_n === 1'b1 && irq === 1'b0, "reset outputs");
		bus(1'b0, `CFPC_OFS_VCO_DIV, 32'h00000000);
		chk(rd === {27'h0000000, `CFPC_VCO_DIV_RST}, "vco div reset");
		bus(1'b0, `CFPC_OFS_LOCK_THR, 32'h00000000);
		chk(rd === {24'h000000, `CFPC_LOCK_THR_RST}, "lock thr reset");
		bus(1'b0, `CFPC_OFS_PRE_DIV, 32'h00000000);
		chk(rd === {27'h0000000, `CFPC_PRE_DIV_RST}, "pre div reset");
		bus(1'b1, 6'h18, 32'hFFFFFFFF);
		bus(1'b0, 6'h18, 32'h00000000);
		chk(rd === 32'h00000000, "unmapped read");
		bus(1'b1, 6'h30, 32'hFFFFFFFF);
		bus(1'b0, `CFPC_OFS_PROFILE0, 32'h00000000);
		chk(rd === 32'h00000000, "unmapped write reached a profile");
		bus(1'b1, `CFPC_OFS_IRQ_MASK, 32'hFFFFFFFF);
		bus(1'b0, `CFPC_OFS_IRQ_MASK, 32'h00000000);
		chk(rd === 32'h00000007, "mask width");
		$display("test regs done");
	endtask : t_regs
	task t_lock;
		bus(1'b1, `CFPC_OFS_IRQ_MASK, 32'h00000001);
		bus(1'b1, `CFPC_OFS_PROFILE0, 32'hF1201000);
		wait_lock(1'b0, 1500);
		ticks(2);
		chk(irq === 1'b1, "lock irq");
		bus(1'b1, `CFPC_OFS_IRQ_STATUS, 32'h00000001);
		chk(irq === 1'b0, "irq clear");
		$display("test lock done");
	endtask : t_lock
	task t_oe;
		drv.output_enable_first <= 1'b0;
		drv.output_enable_second <= 1'b0;
		ticks(6);
		chk(bank_oe_n === 4'hE, "oe both pins low");
		drv.output_enable_first <= 1'b1;
		ticks(6);
		chk(bank_oe_n === 4'hA, "oe first pin");
		drv.output_enable_second <= 1'b1;
		ticks(6);
		chk(bank_oe_n === 4'h2, "oe second pin");
		drv.profile_select_bit0 <= 1'b1;
		ticks(6);
		chk(bank_oe_n === 4'h0, "profile 1 applied");
		bus(1'b0, `CFPC_OFS_PIN_STATUS, 32'h00000000);
		chk(rd[2:1] === 2'h1, "active profile");
		bus(1'b0, `CFPC_OFS_IRQ_STATUS, 32'h00000000);
		chk(rd[2] === 1'b1 && irq === 1'b0, "masked profile event");
		drv.profile_select_bit0 <= 1'b0;
		ticks(6);
		chk(bank_oe_n === 4'h2, "profile 0 again");
		$display("test enables done");
	endtask : t_oe
	task t_fbsel;
		drv.feedback_pair_select <= 1'b1;
		wait_lock(1'b1, 400);
		drv.feedback_pair_select <= 1'b0;
		wait_lock(1'b0, 1500);
		$display("test feedback select done");
	endtask : t_fbsel
	task t_goe;
		// lock lost is still sticky from the feedback test, so clear it first
		bus(1'b1, `CFPC_OFS_IRQ_STATUS, 32'h00000007);
		bus(1'b0, `CFPC_OFS_IRQ_STATUS, 32'h00000000);
		chk(rd[1] === 1'b0, "lock lost cleared");
		drv.global_output_disable <= 1'b1;
		ticks(4);
		chk(bank_oe_n === 4'hF, "global disable");
		chk(lock_n === 1'b1, "lock lost on disable");
		bus(1'b0, `CFPC_OFS_IRQ_STATUS, 32'h00000000);
		chk(rd[1] === 1'b1, "lock lost event");
		drv.global_output_disable <= 1'b0;
		wait_lock(1'b0, 1500);
		$display("test global disable done");
	endtask : t_goe
	task t_lreset;
		drv.loop_reset <= 1'b1;
		ticks(4);
		chk(lock_n === 1'b1, "lock dropped in reset");
		ticks(2);
		runs(20, tg);
		chk(tg == 0, "counters held in reset");
		drv.loop_reset <= 1'b0;
		wait_lock(1'b0, 1500);
		$display("test loop reset done");
	endtask : t_lreset
	task t_gate;
		drv.sync_output_gate <= 1'b0;
		runs(60, tg);
		runs(30, tg);
		chk(tg == 0 && bank_out[3] === 1'b1, "gated bank at idle level");
		drv.sync_output_gate <= 1'b1;
		runs(60, tg);
		chk(tg > 4, "bank runs after ungate");
		$display("test gate done");
	endtask : t_gate
	task t_bypass;
		period(p);
		chk(p == 2 * (`CFPC_VCO_DIV_RST + 1), "vco period");
		drv.loop_bypass <= 1'b1;
		period(p);
		chk(p == 32, "bypass period ref a");
		drv.reference_pair_select <= 1'b1;
		period(p);
		chk(p == 16, "bypass period ref b");
		drv.loop_bypass <= 1'b0;
		drv.reference_pair_select <= 1'b0;
		$display("test bypass done");
	endtask : t_bypass
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		drv.sync_output_gate = 1'b1;
		drv.output_enable_first = 1'b1;
		drv.output_enable_second = 1'b1;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_regs;
		t_lock;
		t_oe;
		t_fbsel;
		t_goe;
		t_lreset;
		t_gate;
		t_bypass;
		results;
	end
endmodule : cfpc_pin_control_test
